// ---- drive_unit_model.sv ----
// Purpose: drive unit model holding its status lines
// Assumes: lines change only between commands
// Notes:   lag of one clock stands for a slow drive
module drive_unit_model (
    input  wire logic       clk,
    input  wire logic [4:0] state,
    output logic      [4:0] lines
);
    // Lines follow the requested state one clock later
    always_ff @(posedge clk) begin
        lines <= state;
    end
endmodule : drive_unit_model

// ---- fdc_result_pkg.sv ----
// Purpose: shared constants for the disk controller result status block
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   termination codes, command encodings, status register bits and pin layout
package fdc_result_pkg;
    // ========================================================
    // Termination codes
    localparam logic [1:0] TERM_NORMAL  = 2'h0;
    localparam logic [1:0] TERM_ABORT   = 2'h1;
    localparam logic [1:0] TERM_INVALID = 2'h2;
    localparam logic [1:0] TERM_READY   = 2'h3;
    // ========================================================
    // Command byte fields and opcodes
    localparam int          CMD_MT_BIT   = 7;
    localparam int          CMD_MF_BIT   = 6;
    localparam logic [4:0]  OP_READ_TRK  = 5'h02;
    localparam logic [4:0]  OP_SENSE_DRV = 5'h04;
    localparam logic [4:0]  OP_WRITE     = 5'h05;
    localparam logic [4:0]  OP_READ      = 5'h06;
    localparam logic [4:0]  OP_RECAL     = 5'h07;
    localparam logic [4:0]  OP_WRITE_DEL = 5'h09;
    localparam logic [4:0]  OP_READ_ID   = 5'h0A;
    localparam logic [4:0]  OP_READ_DEL  = 5'h0C;
    localparam logic [4:0]  OP_FORMAT    = 5'h0D;
    localparam logic [4:0]  OP_SEEK      = 5'h0F;
    localparam logic [4:0]  OP_SCAN_EQ   = 5'h11;
    localparam logic [1:0]  CMD_BYTES    = 2'h3;
    localparam logic [1:0]  RESULT_LAST  = 2'h3;
    // ========================================================
    // Limits and marker values
    localparam logic [6:0]  RECAL_STEPS  = 7'h4D;
    localparam logic [7:0]  CYL_BAD_MARK = 8'hFF;
    // ========================================================
    // Main status register bits
    localparam int          MSR_RQM      = 7;
    localparam int          MSR_DIO      = 6;
    localparam int          MSR_BUSY     = 4;
    // ========================================================
    // Synchronised pin vector layout
    localparam int          PIN_W        = 16;
    localparam int          P_CS_N       = 0;
    localparam int          P_RD_N       = 1;
    localparam int          P_WR_N       = 2;
    localparam int          P_SEL        = 3;
    localparam int          P_FAULT      = 4;
    localparam int          P_WPROT      = 5;
    localparam int          P_READY      = 6;
    localparam int          P_TRK0       = 7;
    localparam int          P_DATA       = 8;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CMD    = 2'b01,
        ST_EXEC   = 2'b10,
        ST_RESULT = 2'b11
    } phase_t;
endpackage : fdc_result_pkg

// ---- fdc_result_status.sv ----
// Purpose: command decode and result status bytes of a disk controller
// Assumes: execution engine on clk reports events as one-cycle pulses
// Notes:   host pins and drive lines are synchronised before use
module fdc_result_status
    import fdc_result_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        register_select_line,
    input  wire logic [7:0]  host_data_in,
    input  wire logic        drive_fault_in,
    input  wire logic        write_protect_in,
    input  wire logic        drive_ready_in,
    input  wire logic        track_zero_in,
    input  wire logic        double_sided_in,
    input  wire logic        eng_done,
    input  wire logic        eng_step,
    input  wire logic        eng_track_end,
    input  wire logic        eng_past_eot,
    input  wire logic        eng_crc_id,
    input  wire logic        eng_crc_data,
    input  wire logic        eng_overrun,
    input  wire logic        eng_no_sector,
    input  wire logic        eng_no_id_mark,
    input  wire logic        eng_no_data_mark,
    input  wire logic        eng_deleted_mark,
    input  wire logic        eng_scan_equal,
    input  wire logic        eng_scan_miss,
    input  wire logic        eng_cyl_valid,
    input  wire logic [7:0]  eng_cyl,
    output logic [7:0]       host_data_out,
    output logic             host_data_oe,
    output logic             irq,
    output logic             exec_start,
    output logic             both_heads_op,
    output logic             density_select,
    output logic             head_sel,
    output logic [1:0]       unit_sel,
    output logic [7:0]       cylinder_req
);
    import fdc_result_pkg::*;

    // ========================================================
    // Pin synchronisation
    pin_sync_if #(.W(PIN_W)) pins ();
    logic double_sided_meta_ff;
    logic double_sided_ff;

    assign pins.raw = {host_data_in, track_zero_in, drive_ready_in,
                       write_protect_in, drive_fault_in,
                       register_select_line, wr_n, rd_n, cs_n};

    pin_sync #(.W(PIN_W)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .pins (pins.sync_side)
    );

    // Two-sided line kept apart from the bus vector
    always_ff @(posedge clk) begin
        if (rst) begin
            double_sided_meta_ff <= 1'b0;
            double_sided_ff      <= 1'b0;
        end else begin
            double_sided_meta_ff <= double_sided_in;
            double_sided_ff      <= double_sided_meta_ff;
        end
    end

    logic       sel_cs;
    logic       sel_rd;
    logic       sel_wr;
    logic       sel_data;
    logic [7:0] bus_byte;
    logic       fault_s;
    logic       wprot_s;
    logic       ready_s;
    logic       trk0_s;

    assign sel_cs   = ~pins.synced[P_CS_N];
    assign sel_rd   = sel_cs & ~pins.synced[P_RD_N];
    assign sel_wr   = sel_cs & ~pins.synced[P_WR_N];
    assign sel_data = pins.synced[P_SEL];
    assign bus_byte = pins.synced[P_DATA +: 8];
    assign fault_s  = pins.synced[P_FAULT];
    assign wprot_s  = pins.synced[P_WPROT];
    assign ready_s  = pins.synced[P_READY];
    assign trk0_s   = pins.synced[P_TRK0];

    // ========================================================
    // Strobe edge detection
    logic rd_prev_ff;
    logic wr_prev_ff;
    logic rd_end;
    logic wr_end;

    // Act at the trailing edge so bus data has settled
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
        end else begin
            rd_prev_ff <= sel_rd;
            wr_prev_ff <= sel_wr;
        end
    end
    assign rd_end = rd_prev_ff & ~sel_rd;
    assign wr_end = wr_prev_ff & ~sel_wr;

    // ========================================================
    // Phase sequencing
    phase_t     phase_ff;
    phase_t     nxt_phase;
    logic [1:0] cnt_ff;
    logic [4:0] opcode_ff;
    logic       skip_ff;
    logic       valid_op;
    logic       rw_op;
    logic       wr_op;
    logic       start_bad;
    logic       exec_end;
    logic       recal_fail;

    always_comb begin
        case (opcode_ff)
            OP_READ_TRK, OP_SENSE_DRV, OP_WRITE, OP_READ, OP_RECAL,
            OP_WRITE_DEL, OP_READ_ID, OP_READ_DEL, OP_FORMAT, OP_SEEK,
            OP_SCAN_EQ: valid_op = 1'b1;
            default:    valid_op = 1'b0;
        endcase
    end

    assign wr_op = (opcode_ff == OP_WRITE) | (opcode_ff == OP_WRITE_DEL)
                 | (opcode_ff == OP_FORMAT);
    assign rw_op = wr_op | (opcode_ff == OP_READ) | (opcode_ff == OP_READ_DEL)
                 | (opcode_ff == OP_READ_TRK) | (opcode_ff == OP_READ_ID)
                 | (opcode_ff == OP_SCAN_EQ);
    assign start_bad = rw_op & (~ready_s | (head_sel & ~double_sided_ff));

    logic       cmd_last;
    assign cmd_last = wr_end & sel_data & (cnt_ff == CMD_BYTES - 2'h1);
    // unknown opcode never starts, so it ends at once
    assign exec_end = eng_done | recal_fail | ~valid_op;

    // Writes outside the command phases are ignored
    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            ST_IDLE: begin
                if (wr_end && sel_data) begin
                    nxt_phase = ST_CMD;
                end
            end
            ST_CMD: begin
                if (cmd_last) begin
                    nxt_phase = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (exec_end) begin
                    nxt_phase = ST_RESULT;
                end
            end
            ST_RESULT: begin
                if (rd_end && sel_data && cnt_ff == RESULT_LAST) begin
                    nxt_phase = ST_IDLE;
                end
            end
            default: nxt_phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_ff <= ST_IDLE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Byte counter for both command and result transfers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 2'h0;
        end else if (phase_ff != nxt_phase) begin
            cnt_ff <= (nxt_phase == ST_CMD) ? 2'h1 : 2'h0;
        end else if ((phase_ff == ST_CMD && wr_end && sel_data) ||
                     (phase_ff == ST_RESULT && rd_end && sel_data)) begin
            cnt_ff <= cnt_ff + 2'h1;
        end
    end

    // ========================================================
    // Command parameter capture
    // multi-track bit kept
    always_ff @(posedge clk) begin
        if (rst) begin
            opcode_ff      <= 5'h00;
            skip_ff        <= 1'b0;
            both_heads_op  <= 1'b0;
            density_select <= 1'b0;
        end else if (phase_ff == ST_IDLE && wr_end && sel_data) begin
            opcode_ff      <= bus_byte[4:0];
            skip_ff        <= bus_byte[5];
            both_heads_op  <= bus_byte[CMD_MT_BIT];
            density_select <= bus_byte[CMD_MF_BIT];
        end
    end

    // move to head 1 on track end
    always_ff @(posedge clk) begin
        if (rst) begin
            head_sel     <= 1'b0;
            unit_sel     <= 2'h0;
            cylinder_req <= 8'h00;
        end else if (phase_ff == ST_CMD && wr_end && sel_data) begin
            if (cnt_ff == 2'h1) begin
                head_sel <= bus_byte[2];
                unit_sel <= bus_byte[1:0];
            end else begin
                cylinder_req <= bus_byte;
            end
        end else if (phase_ff == ST_EXEC && eng_track_end && both_heads_op
                     && !head_sel) begin
            head_sel <= 1'b1;
        end
    end

    // Start pulse for every valid opcode, also when the drive is not ready
    always_ff @(posedge clk) begin
        if (rst) begin
            exec_start <= 1'b0;
        end else begin
            exec_start <= (nxt_phase == ST_EXEC) && (phase_ff != ST_EXEC) && valid_op;
        end
    end

    // ========================================================
    // Recalibrate step counting
    logic [6:0] step_cnt_ff;
    always_ff @(posedge clk) begin
        if (rst || phase_ff != ST_EXEC) begin
            step_cnt_ff <= 7'h00;
        end else if (eng_step && step_cnt_ff != RECAL_STEPS) begin
            step_cnt_ff <= step_cnt_ff + 7'h01;
        end
    end
    assign recal_fail = (phase_ff == ST_EXEC) && (opcode_ff == OP_RECAL)
                      && (step_cnt_ff == RECAL_STEPS) && !trk0_s;

    // ========================================================
    // Event flags collected during execution
    logic end_cyl_ff;
    logic crc_any_ff;
    logic overrun_ff;
    logic no_sector_ff;
    logic id_absent_ff;
    logic deleted_ff;
    logic data_crc_ff;
    logic cyl_mis_ff;
    logic cyl_bad_ff;
    logic scan_hit_ff;
    logic scan_fail_ff;
    logic data_absent_ff;
    logic fault_seen_ff;
    logic ready_chg_ff;
    logic ready_start_ff;
    logic in_exec;
    logic clr_flags;
    logic read_cmd;

    assign in_exec   = (phase_ff == ST_EXEC);
    assign clr_flags = (phase_ff == ST_CMD) && cmd_last;
    assign read_cmd  = (opcode_ff == OP_READ) | (opcode_ff == OP_SCAN_EQ);

    // Flags clear only at execution start, so no event is lost
    always_ff @(posedge clk) begin
        if (rst || clr_flags) begin
            end_cyl_ff     <= 1'b0;
            crc_any_ff     <= 1'b0;
            overrun_ff     <= 1'b0;
            no_sector_ff   <= 1'b0;
            id_absent_ff   <= 1'b0;
            deleted_ff     <= 1'b0;
            data_crc_ff    <= 1'b0;
            scan_hit_ff    <= 1'b0;
            scan_fail_ff   <= 1'b0;
            data_absent_ff <= 1'b0;
            fault_seen_ff  <= 1'b0;
        end else if (in_exec) begin
            end_cyl_ff <= end_cyl_ff | (eng_past_eot & ~(both_heads_op & ~head_sel));
            crc_any_ff <= crc_any_ff | eng_crc_id | eng_crc_data;
            overrun_ff <= overrun_ff | eng_overrun;
            no_sector_ff <= no_sector_ff | eng_no_sector;
            id_absent_ff <= id_absent_ff | eng_no_id_mark;
            deleted_ff <= deleted_ff | (eng_deleted_mark & read_cmd);
            data_crc_ff <= data_crc_ff | eng_crc_data;
            scan_hit_ff  <= scan_hit_ff | (eng_scan_equal & (opcode_ff == OP_SCAN_EQ));
            scan_fail_ff <= scan_fail_ff | (eng_scan_miss & (opcode_ff == OP_SCAN_EQ));
            data_absent_ff <= data_absent_ff | eng_no_data_mark | eng_no_id_mark;
            fault_seen_ff <= fault_seen_ff | fault_s | recal_fail;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clr_flags) begin
            cyl_mis_ff <= 1'b0;
            cyl_bad_ff <= 1'b0;
        end else if (in_exec && eng_cyl_valid && eng_cyl != cylinder_req) begin
            cyl_mis_ff <= 1'b1;
            cyl_bad_ff <= cyl_bad_ff | (eng_cyl == CYL_BAD_MARK);
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clr_flags) begin
            ready_start_ff <= ready_s;
            ready_chg_ff   <= 1'b0;
        end else if (in_exec && ready_s != ready_start_ff) begin
            ready_chg_ff <= 1'b1;
        end
    end

    // ========================================================
    // Result byte capture
    logic [7:0] res_ff [4];
    logic [1:0] term;
    logic       abnormal;
    logic       unready;

    assign unready  = start_bad;
    assign abnormal = end_cyl_ff | crc_any_ff | overrun_ff | no_sector_ff
                    | id_absent_ff | data_absent_ff | cyl_mis_ff
                    | scan_fail_ff | fault_seen_ff | recal_fail
                    | (wr_op & wprot_s);

    always_comb begin
        if (!valid_op) begin
            term = TERM_INVALID;
        end else if (ready_chg_ff) begin
            term = TERM_READY;
        end else if (abnormal || unready) begin
            term = TERM_ABORT;
        end else begin
            term = TERM_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                res_ff[i] <= 8'h00;
            end
        end else if (in_exec && exec_end) begin
            res_ff[0] <= {term,
                          (opcode_ff == OP_SEEK) | (opcode_ff == OP_RECAL),
                          fault_seen_ff | fault_s | recal_fail,
                          unready, head_sel, unit_sel};
            res_ff[1] <= {end_cyl_ff, 1'b0, crc_any_ff, overrun_ff, 1'b0,
                          no_sector_ff, wr_op & wprot_s, id_absent_ff};
            res_ff[2] <= {1'b0, deleted_ff, data_crc_ff, cyl_mis_ff,
                          scan_hit_ff, scan_fail_ff, cyl_bad_ff, data_absent_ff};
            res_ff[3] <= {fault_s, wprot_s, ready_s, trk0_s,
                          double_sided_ff, head_sel, unit_sel};
        end
    end

    // ========================================================
    // Host read path
    logic [7:0] msr;
    logic       skip_unused;
    assign skip_unused = skip_ff;
    assign msr = {(phase_ff != ST_EXEC), (phase_ff == ST_RESULT), 1'b0,
                  (phase_ff != ST_IDLE), 3'h0, skip_unused & 1'b0};

    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_out <= 8'h00;
            host_data_oe  <= 1'b0;
        end else begin
            host_data_oe <= sel_rd;
            if (!sel_data) begin
                host_data_out <= msr;
            end else if (phase_ff == ST_RESULT) begin
                host_data_out <= res_ff[cnt_ff];
            end else begin
                host_data_out <= 8'h00;
            end
        end
    end

    // Completion raised the cycle after the bytes are stored
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (phase_ff == ST_RESULT && nxt_phase == ST_RESULT) begin
            irq <= 1'b1;
        end else begin
            irq <= 1'b0;
        end
    end
endmodule : fdc_result_status

// ---- fdc_result_status_assertions.sv ----
// Purpose: port checks of the result status block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the top module
module fdc_result_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       rd_n,
    input wire logic [7:0] host_data_out,
    input wire logic       host_data_oe,
    input wire logic       irq,
    input wire logic       exec_start,
    input wire logic       both_heads_op,
    input wire logic       density_select,
    input wire logic [7:0] cylinder_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Sequences
    sequence s_params_still;
        $stable({both_heads_op, density_select, cylinder_req})[*4];
    endsequence
    sequence s_irq_kept;
        irq[*8];
    endsequence
    // ==========================================
    // Checks
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !host_data_oe)
        else $error("outputs active after reset");
    a_start_pulse: assert property (exec_start |=> !exec_start)
        else $error("start pulse too long");
    a_irq_excl: assert property (exec_start |-> !irq)
        else $error("irq during execution");
    a_param_hold: assert property (exec_start |=> s_params_still)
        else $error("parameters moved in execution");
    a_oe_cause: assert property (host_data_oe |->
        !($past(rd_n, 1) && $past(rd_n, 2) && $past(rd_n, 3) && $past(rd_n, 4) && $past(rd_n, 5)))
        else $error("data driven without read");
    a_oe_release: assert property ($rose(rd_n) |-> ##[1:6] !host_data_oe)
        else $error("data not released");
    a_read_hold: assert property (host_data_oe && $past(host_data_oe) |-> $stable(host_data_out))
        else $error("read data moved");
    a_irq_kept: assert property ($rose(irq) |-> s_irq_kept)
        else $error("irq dropped early");
endmodule : fdc_result_checker
bind fdc_result_status fdc_result_checker fdc_result_checker_i (
    .clk(clk), .rst(rst), .rd_n(rd_n), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .irq(irq), .exec_start(exec_start),
    .both_heads_op(both_heads_op), .density_select(density_select),
    .cylinder_req(cylinder_req)
);

// ---- pin_sync.sv ----
// Purpose: two-stage synchroniser for every pin of the bus vector
// Assumes: pins change slowly against the 40 ns clock
// Notes:   first stage feeds only the second stage
module pin_sync #(
    parameter int W = 16
) (
    input  wire logic      clk,
    input  wire logic      rst,
    pin_sync_if.sync_side  pins
);
    // ========================================================
    // Per-bit double flop
    generate
        for (genvar i = 0; i < W; i++) begin : g_bit
            logic meta_ff;
            logic hold_ff;
            // Reset to one keeps active-low strobes idle
            always_ff @(posedge clk) begin
                if (rst) begin
                    meta_ff <= 1'b1;
                    hold_ff <= 1'b1;
                end else begin
                    meta_ff <= pins.raw[i];
                    hold_ff <= meta_ff;
                end
            end
            assign pins.synced[i] = hold_ff;
        end
    endgenerate
endmodule : pin_sync

// ---- pin_sync_if.sv ----
// Purpose: carrier between the pin synchroniser and the controller
// Assumes: raw pins asynchronous to clk
// Notes:   synced is safe to read by any logic
interface pin_sync_if #(parameter int W = 16);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface : pin_sync_if

// ---- tb.sv ----
// Purpose: self-checking bench for the result status block
// Assumes: 25 MHz clock, synchronous reset
// Notes:   expected bytes rebuilt from flag meanings
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fdc_result_pkg::*;
    logic        clk, rst, cs_n, rd_n, wr_n, sel, done, stp, oe, irq, xs, mt_o, mf_o, hs_o;
    logic [7:0]  din, cyl_m, dout, cyl_o, got;
    logic [11:0] ev;
    logic [4:0]  dstate, dline;
    logic [1:0]  us_o;
    integer      n_fail, cmp_count, seed, i, n_start = 0;
    drive_unit_model drive_unit_model_i (.clk(clk), .state(dstate), .lines(dline));
    fdc_result_status fdc_result_status_i (
        .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .register_select_line(sel), .host_data_in(din), .drive_fault_in(dline[4]),
        .write_protect_in(dline[3]), .drive_ready_in(dline[2]),
        .track_zero_in(dline[1]), .double_sided_in(dline[0]), .eng_done(done),
        .eng_step(stp), .eng_track_end(ev[11]), .eng_past_eot(ev[10]),
        .eng_crc_id(ev[9]), .eng_crc_data(ev[8]), .eng_overrun(ev[7]),
        .eng_no_sector(ev[6]), .eng_no_id_mark(ev[5]), .eng_no_data_mark(ev[4]),
        .eng_deleted_mark(ev[3]), .eng_scan_equal(ev[2]), .eng_scan_miss(ev[1]),
        .eng_cyl_valid(ev[0]), .eng_cyl(cyl_m), .host_data_out(dout),
        .host_data_oe(oe), .irq(irq), .exec_start(xs), .both_heads_op(mt_o),
        .density_select(mf_o), .head_sel(hs_o), .unit_sel(us_o), .cylinder_req(cyl_o)
    );
    // ==========================================
    // Clock and start counter
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counted so a start pulse inside a strobe is not missed
    always @(posedge clk) begin
        if (xs === 1'b1) begin
            n_start <= n_start + 1;
        end
    end
    // ==========================================
    // Tasks
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    // Strobes held 4 clocks low, 4 high: sync needs 3
    task automatic hw(input logic [7:0] d);
        sel <= 1'b1;
        din <= d;
        {cs_n, wr_n} <= 2'h0;
        repeat (4) @(posedge clk);
        {cs_n, wr_n} <= 2'h3;
        repeat (4) @(posedge clk);
    endtask : hw
    task automatic hr(input logic s, output logic [7:0] d);
        sel <= s;
        {cs_n, rd_n} <= 2'h0;
        repeat (4) @(posedge clk);
        // Sample away from the launching edge
        @(negedge clk);
        d = dout;
        check({7'h0, oe}, 8'h01);
        @(posedge clk);
        {cs_n, rd_n} <= 2'h3;
        repeat (4) @(posedge clk);
    endtask : hr
    task automatic run(input logic [7:0] b0, input logic [11:0] e, input logic [7:0] m0);
        logic [7:0] b1, cy, x0, x1, x2;
        logic       hd, bad, na, ab, rc, inv;
        integer     k, s0;
        b1 = {5'h0, 3'($random(seed))};
        cy = 8'($random(seed));
        cyl_m <= 8'($random(seed));
        rc = b0[4:0] == OP_RECAL;
        inv = b0[4:0] == 5'h1F;
        hd = (b0[7] && e[11]) | b1[2];
        s0 = n_start;
        hw(b0);
        hw(b1);
        hw(cy);
        na = !dline[2] && (b0[4:0] == OP_READ || b0[4:0] == OP_WRITE);
        bad = e[0] && cyl_m != cy;
        x1 = {e[10] && !(b0[7] && !b1[2]), 1'b0, e[9] | e[8], e[7], 1'b0, e[6],
              dline[3] && b0[4:0] == OP_WRITE, e[5]};
        x2 = {1'b0, e[3], e[8], bad, e[2], e[1], bad && cyl_m == CYL_BAD_MARK, e[5] | e[4]};
        ab = |x1 || |(x2 & 8'h37) || na || dline[4] || rc;
        x0 = {inv, ab && !inv, (b0[4:0] == OP_SEEK) || rc, dline[4] | rc, na, hd, b1[1:0]};
        for (k = 0; k < 40 && n_start == s0 && !inv; k++) @(posedge clk);
        check({mt_o, mf_o, us_o, 4'h0}, {b0[7:6], b1[1:0], 4'h0});
        check(cyl_o, cy);
        for (k = 0; k < 77 && rc; k++) begin
            stp <= 1'b1;
            @(posedge clk);
            stp <= 1'b0;
            @(posedge clk);
        end
        if (!rc && !inv) begin
            ev <= e;
            @(posedge clk);
            ev <= '0;
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
        end
        for (k = 0; k < 40 && irq !== 1'b1; k++) @(posedge clk);
        hr(1'b1, got);
        check(got & m0, x0 & m0);
        hr(1'b1, got);
        check(got, x1);
        hr(1'b1, got);
        check(got, x2);
        hr(1'b1, got);
        check(got, {dline, hd, b1[1:0]});
        check({7'h0, irq}, 8'h00);
        check({7'h0, hs_o}, {7'h0, hd});
        $display("test %h ended", b0);
    endtask : run
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    // ==========================================
    // Main sequence: idle reads, every flag, faults, recalibrate, bad opcode
    initial begin
        {n_fail, cmp_count, seed} = {32'h0, 32'h0, 32'h6723};
        {rst, cs_n, rd_n, wr_n, sel, done, stp} = 7'h0F << 3;
        {din, cyl_m, ev, dstate} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        dstate <= 5'h05;
        repeat (4) @(posedge clk);
        hr(1'b0, got);
        check(got, 8'h80);
        hr(1'b1, got);
        check(got, 8'h00);
        run({3'h0, OP_SEEK}, 12'h0, 8'hFF);
        for (i = 0; i < 12; i++) begin
            run({2'($random(seed)), 1'b0, (i == 1 || i == 2) ? OP_SCAN_EQ :
                 (i == 6) ? OP_READ_ID : (i == 7) ? OP_READ_TRK : OP_READ},
                12'(1 << i), 8'hFF);
        end
        dstate <= 5'h1D;
        run({3'h0, OP_WRITE}, 12'h0, 8'hFF);
        dstate <= 5'h01;
        run({3'h0, OP_READ}, 12'h0, 8'hFF);
        dstate <= 5'h05;
        run({3'h0, OP_RECAL}, 12'h0, 8'hFF);
        run(8'h1F, 12'h0, 8'hFF);
        stop_test();
    end
    // Watchdog well beyond the expected 1280 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule : tb
